// ### shared/safety_cfg.svh
// Addresses, field positions, reset values and timing figures of the output-block control.
`ifndef SAFETY_CFG_SVH
`define SAFETY_CFG_SVH

// ======================================================================
// Register byte addresses
`define IN_CFG_ADDR 8'h00
`define BLK_CFG_ADDR 8'h04
`define DELAY_A_ADDR 8'h08
`define DELAY_B_ADDR 8'h0c
`define STATUS_ADDR 8'h10
`define IRQ_STAT_ADDR 8'h14
`define IRQ_MASK_ADDR 8'h18

// ======================================================================
// Per-input configuration nibble
`define IN_NIB_W 4
`define IN_MAP_A 0
`define IN_DLY_EN 2
`define IN_OVR_EN 3

// ======================================================================
// Per-block configuration nibble
`define BLK_NIB_W 4
`define BLK_FB_EN 0
`define BLK_DLY_EN 1
`define BLK_AUTO 2
`define BLK_PNP 3

// ======================================================================
// Status and interrupt layout
`define ST_ACTIVE 0
`define ST_CLOSED 2
`define ST_DELAY 4
`define ST_SAFE 8
`define IRQ_TRIP 0
`define IRQ_FAULT 2
`define IRQ_CLOSE 4
`define IRQ_W 6

// ======================================================================
// Reset values
`define IN_CFG_RST 32'h0000_0000
`define BLK_CFG_RST 8'h00
`define DELAY_RST 32'h0000_0000
`define IRQ_MASK_RST 6'h00

// ======================================================================
// Timing
`define CLK_HZ 125000000
`define FB_CHECK_MS 300
`define FB_CHECK_TICKS (`FB_CHECK_MS * (`CLK_HZ / 1000))

`endif

// ### shared/safety_pkg.sv
// Types shared by the output-block control modules.
`default_nettype none
package safety_pkg;

  // ======================================================================
  // Output block states
  typedef enum logic [2:0]
  {
    ST_OPEN = 3'b001,
    ST_CLOSED = 3'b010,
    ST_DELAY = 3'b100
  } blk_state_e;

endpackage
`default_nettype wire

// ### design/stop_delay_timer.sv
// Tick counter that delays the opening of one output block.
`timescale 1ns/1ns
`default_nettype none
module stop_delay_timer
#(
  parameter int W = 32
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic abort,
  input wire logic [W-1:0] load_val,
  output logic done
);

  logic [W-1:0] cnt_ff;
  logic armed_ff;

  // ======================================================================
  // Counter: loaded at the start of a delayed trip, counts down to zero.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff <= '0;
      armed_ff <= 1'b0;
    end
    else if (load)
    begin
      cnt_ff <= load_val; // RULE10
      armed_ff <= 1'b1;
    end
    else if (abort || (armed_ff && cnt_ff == '0))
      armed_ff <= 1'b0;
    else if (armed_ff)
      cnt_ff <= cnt_ff - W'(1); // RULE10
  end

  // Expiry is a level while armed at zero; the block leaves its delay state on it.
  assign done = armed_ff && (cnt_ff == '0);

  // ======================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // The load edge always sees abort high, so expiry is judged on the last count instead.
  property p_expire_after_one;
    armed_ff && !load && !abort && cnt_ff == W'(1) |=> done;
  endproperty
  a_expire_after_one: assert property (p_expire_after_one) else $error("delay did not expire on time"); // RULE10

  property p_no_early_expiry;
    load && load_val != '0 |=> !done;
  endproperty
  a_no_early_expiry: assert property (p_no_early_expiry) else $error("delay expired at load"); // RULE10

endmodule
`default_nettype wire

// ### design/contactor_feedback_check.sv
// Contactor feedback monitor for one output block.
`timescale 1ns/1ns
`default_nettype none
`include "safety_cfg.svh"
module contactor_feedback_check
#(
  parameter int W = 32,
  parameter logic [W-1:0] TICKS = W'(`FB_CHECK_TICKS)
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic out_closed,
  input wire logic fb_closed,
  output logic start_ok,
  output logic fault
);

  logic closed_prev_ff;
  logic fb_prev_ff;
  logic [W-1:0] tmr_ff;
  logic [1:0] edges_ff;
  logic fault_ff;
  logic [W-1:0] nxt_tmr;
  logic [1:0] nxt_edges;

  // ======================================================================
  // Decode: closing edge, feedback edge and the two fault causes.
  wire close_rise = out_closed && !closed_prev_ff;
  wire fb_edge = fb_closed ^ fb_prev_ff;
  wire timeout = enable && out_closed && fb_closed && tmr_ff == W'(1);
  // A second feedback edge while monitoring is off means the contact is live.
  wire toggle = !enable && fb_edge && edges_ff == 2'h1;

  // The watch only runs while the contact stays closed behind a closed block.
  assign nxt_tmr = (!enable || !out_closed || !fb_closed) ? '0 :
                   close_rise ? TICKS : (tmr_ff != '0) ? tmr_ff - W'(1) : tmr_ff;
  assign nxt_edges = (enable || toggle) ? 2'h0 : (fb_edge && edges_ff != 2'h2) ? edges_ff + 2'h1 : edges_ff;

  // With monitoring enabled, start is allowed only with the normally closed contact closed; with it off, start is always allowed.
  assign start_ok = !enable || fb_closed; // RULE2
  assign fault = fault_ff;

  // ======================================================================
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      closed_prev_ff <= 1'b0;
      fb_prev_ff <= 1'b1; // An idle NC contact reads closed, so release of reset brings no false edge.
      tmr_ff <= '0;
      edges_ff <= 2'h0;
      fault_ff <= 1'b0;
    end
    else
    begin
      closed_prev_ff <= out_closed;
      fb_prev_ff <= fb_closed;
      tmr_ff <= nxt_tmr;
      edges_ff <= nxt_edges;
      fault_ff <= timeout || toggle; // RULE3 RULE4
    end
  end

  // ======================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_timeout_fault;
    enable && out_closed && fb_closed && tmr_ff == W'(1) |=> fault;
  endproperty
  a_timeout_fault: assert property (p_timeout_fault) else $error("feedback timeout missed"); // RULE3

  property p_toggle_fault;
    !enable && edges_ff == 2'h1 && (fb_closed != fb_prev_ff) |=> fault;
  endproperty
  a_toggle_fault: assert property (p_toggle_fault) else $error("toggling feedback not caught"); // RULE4

endmodule
`default_nettype wire

// ### design/safety_output_block_ctrl.sv
// Output-block control of the safety controller with its APB register file.
`timescale 1ns/1ns
`default_nettype none
`include "safety_cfg.svh"
// Summary of operation
// [RULE1] Block active only with an input mapped
// [RULE2] Feedback check: start only with contact closed
// [RULE3] Feedback must open within 300 ms
// [RULE4] Toggling feedback while unchecked opens block
// [RULE5] Delay needs block and input enables
// [RULE6] Reclose automatically or on start button
// [RULE7] Each input opens only its mapped blocks
// [RULE8] Override suppresses trip only where enabled
// [RULE9] Unfitted block left unmapped by software
// [RULE10] Delay counts clock ticks from configured value
module safety_output_block_ctrl
#(
  parameter int NUM_IN = 6,
  parameter int DLY_W = 32,
  parameter logic [31:0] FB_TICKS = 32'(`FB_CHECK_TICKS)
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_IN-1:0] safe_in,
  input wire logic [1:0] start_btn,
  input wire logic override_sw,
  input wire logic [1:0] fb_in,
  output logic [1:0] block_closed,
  output logic [1:0] block_pnp,
  output logic irq
);

  localparam logic [31:0] IN_MASK = 32'((64'h1 << (NUM_IN * `IN_NIB_W)) - 64'h1);

  // Picks one bit of every input nibble.
  function automatic logic [NUM_IN-1:0] field_vec(input logic [31:0] cfg, input int pos);
    logic [NUM_IN-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_IN; i++)
      v[i] = cfg[i * `IN_NIB_W + pos];
    return v;
  endfunction

  logic [31:0] in_cfg_ff;
  logic [7:0] blk_cfg_ff;
  logic [DLY_W-1:0] delay_ff [2];
  logic [`IRQ_W-1:0] irq_stat_ff;
  logic [`IRQ_W-1:0] irq_mask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic [1:0] closed_ff;
  logic [1:0] start_prev_ff;
  safety_pkg::blk_state_e st_ff [2];
  safety_pkg::blk_state_e nxt_st [2];
  logic [1:0] nxt_closed;
  logic [1:0] dly_load;
  logic [`IRQ_W-1:0] nxt_irq_stat;
  logic [31:0] rd_mux;

  // ======================================================================
  // APB decode. The slave answers in the first access cycle, never later.
  wire setup = psel && !penable;
  wire access = psel && penable && pready_ff;
  wire wr_en = access && pwrite && !pslverr_ff;
  wire rd_en = access && !pwrite && !pslverr_ff;
  wire hit_in = paddr == `IN_CFG_ADDR;
  wire hit_blk = paddr == `BLK_CFG_ADDR;
  wire hit_dla = paddr == `DELAY_A_ADDR;
  wire hit_dlb = paddr == `DELAY_B_ADDR;
  wire hit_st = paddr == `STATUS_ADDR;
  wire hit_is = paddr == `IRQ_STAT_ADDR;
  wire hit_im = paddr == `IRQ_MASK_ADDR;
  wire addr_ok = hit_in || hit_blk || hit_dla || hit_dlb || hit_st || hit_is || hit_im;

  // ======================================================================
  // Per-input fields and trip qualification.
  wire [NUM_IN-1:0] map_a = field_vec(in_cfg_ff, `IN_MAP_A);
  wire [NUM_IN-1:0] map_b = field_vec(in_cfg_ff, `IN_MAP_A + 1);
  wire [NUM_IN-1:0] in_dly = field_vec(in_cfg_ff, `IN_DLY_EN);
  wire [NUM_IN-1:0] in_ovr = field_vec(in_cfg_ff, `IN_OVR_EN);
  // An override only hides the trips of inputs that allow it.
  wire [NUM_IN-1:0] trip_in = ~safe_in & ~(in_ovr & {NUM_IN{override_sw}}); // RULE8

  wire [1:0] active;
  wire [1:0] trip_imm;
  wire [1:0] trip_dly;
  wire [1:0] all_clear;
  wire [1:0] go;
  wire [1:0] start_ok;
  wire [1:0] fb_fault;
  wire [1:0] dly_done;
  wire [1:0] in_delay;

  // ======================================================================
  // Per-block decisions, feedback monitors and stop-delay timers.
  for (genvar b = 0; b < 2; b++)
  begin : g_blk
    wire [NUM_IN-1:0] map = (b == 0) ? map_a : map_b;
    wire blk_dly = blk_cfg_ff[b * `BLK_NIB_W + `BLK_DLY_EN];
    wire [NUM_IN-1:0] dly_sel = in_dly & {NUM_IN{blk_dly}};
    assign active[b] = |map; // RULE1
    assign trip_imm[b] = |(trip_in & map & ~dly_sel); // RULE5 RULE7
    assign trip_dly[b] = |(trip_in & map & dly_sel); // RULE5
    assign all_clear[b] = ~|(trip_in & map);
    // A start button counts on its press, not while it is held.
    assign go[b] = active[b] && all_clear[b] && start_ok[b] && !fb_fault[b] &&
                   (blk_cfg_ff[b * `BLK_NIB_W + `BLK_AUTO] || (start_btn[b] && !start_prev_ff[b])); // RULE6 RULE2
    assign in_delay[b] = st_ff[b] == safety_pkg::ST_DELAY;

    contactor_feedback_check #(.W(32), .TICKS(FB_TICKS)) u_fb
    (
      .ref_clk(ref_clk),
      .rst(rst),
      .enable(blk_cfg_ff[b * `BLK_NIB_W + `BLK_FB_EN]),
      .out_closed(closed_ff[b]),
      .fb_closed(fb_in[b]),
      .start_ok(start_ok[b]),
      .fault(fb_fault[b])
    );

    stop_delay_timer #(.W(DLY_W)) u_dly
    (
      .ref_clk(ref_clk),
      .rst(rst),
      .load(dly_load[b]),
      .abort(!in_delay[b]),
      .load_val(delay_ff[b]),
      .done(dly_done[b])
    );
  end

  // ======================================================================
  // Block state machines. Any immediate trip or fault wins over a running delay.
  always_comb
  begin
    for (int b = 0; b < 2; b++)
    begin
      nxt_st[b] = st_ff[b];
      dly_load[b] = 1'b0;
      unique case (st_ff[b])
        safety_pkg::ST_OPEN:
          if (go[b])
            nxt_st[b] = safety_pkg::ST_CLOSED; // RULE6
        safety_pkg::ST_CLOSED:
          if (trip_imm[b] || fb_fault[b] || !active[b])
            nxt_st[b] = safety_pkg::ST_OPEN; // RULE3 RULE4 RULE7
          else if (trip_dly[b])
          begin
            nxt_st[b] = safety_pkg::ST_DELAY;
            dly_load[b] = 1'b1; // RULE10
          end
        safety_pkg::ST_DELAY:
          if (trip_imm[b] || fb_fault[b] || !active[b] || dly_done[b])
            nxt_st[b] = safety_pkg::ST_OPEN; // RULE5 RULE10
        default:
          nxt_st[b] = safety_pkg::ST_OPEN;
      endcase
      nxt_closed[b] = nxt_st[b] != safety_pkg::ST_OPEN;
    end
  end

  // ======================================================================
  // Events and read data. A read clears only the bits it returned, so a new event wins.
  wire [1:0] ev_trip = closed_ff & ~nxt_closed;
  wire [1:0] ev_close = ~closed_ff & nxt_closed;
  wire [`IRQ_W-1:0] rd_clr = (rd_en && hit_is) ? prdata_ff[`IRQ_W-1:0] : '0;
  assign nxt_irq_stat = (irq_stat_ff & ~rd_clr) | {ev_close, fb_fault, ev_trip};

  always_comb
  begin
    rd_mux = '0;
    if (hit_in)
      rd_mux = in_cfg_ff;
    else if (hit_blk)
      rd_mux[7:0] = blk_cfg_ff;
    else if (hit_dla)
      rd_mux[DLY_W-1:0] = delay_ff[0];
    else if (hit_dlb)
      rd_mux[DLY_W-1:0] = delay_ff[1];
    else if (hit_st)
    begin
      rd_mux[`ST_ACTIVE +: 2] = active;
      rd_mux[`ST_CLOSED +: 2] = closed_ff;
      rd_mux[`ST_DELAY +: 2] = in_delay;
      rd_mux[`ST_SAFE +: NUM_IN] = safe_in;
    end
    else if (hit_is)
      rd_mux[`IRQ_W-1:0] = irq_stat_ff;
    else if (hit_im)
      rd_mux[`IRQ_W-1:0] = irq_mask_ff;
  end

  // ======================================================================
  // Bus answer, captured in the setup cycle so every output is a flop.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end
    else
    begin
      pready_ff <= setup;
      pslverr_ff <= setup && !addr_ok;
      prdata_ff <= setup ? rd_mux : '0;
    end
  end

  // ======================================================================
  // Configuration registers, written at the access edge only.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      in_cfg_ff <= `IN_CFG_RST;
      blk_cfg_ff <= `BLK_CFG_RST;
      delay_ff[0] <= DLY_W'(`DELAY_RST);
      delay_ff[1] <= DLY_W'(`DELAY_RST);
      irq_mask_ff <= `IRQ_MASK_RST;
    end
    else if (wr_en)
    begin
      if (hit_in)
        in_cfg_ff <= pwdata & IN_MASK; // RULE7 RULE8
      if (hit_blk)
        blk_cfg_ff <= pwdata[7:0];
      if (hit_dla)
        delay_ff[0] <= pwdata[DLY_W-1:0];
      if (hit_dlb)
        delay_ff[1] <= pwdata[DLY_W-1:0];
      if (hit_im)
        irq_mask_ff <= pwdata[`IRQ_W-1:0];
    end
  end

  // ======================================================================
  // Block state, outputs and interrupt.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff[0] <= safety_pkg::ST_OPEN;
      st_ff[1] <= safety_pkg::ST_OPEN;
      closed_ff <= 2'h0;
      start_prev_ff <= 2'h0;
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      st_ff[0] <= nxt_st[0];
      st_ff[1] <= nxt_st[1];
      closed_ff <= nxt_closed;
      start_prev_ff <= start_btn;
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign block_closed = closed_ff;
  assign block_pnp = {blk_cfg_ff[`BLK_NIB_W + `BLK_PNP], blk_cfg_ff[`BLK_PNP]};
  assign irq = irq_ff;

  // ======================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_inactive_open;
    1'b1 |=> ((~$past(active) & closed_ff) == 2'h0);
  endproperty
  a_inactive_open: assert property (p_inactive_open) else $error("unmapped block closed"); // RULE1

  property p_start_needs_contact;
    $rose(closed_ff[0]) && $past(blk_cfg_ff[`BLK_FB_EN]) |-> $past(fb_in[0]);
  endproperty
  a_start_needs_contact: assert property (p_start_needs_contact) else $error("start with contact open"); // RULE2

  property p_imm_trip_opens;
    closed_ff[1] && trip_imm[1] |=> !closed_ff[1];
  endproperty
  a_imm_trip_opens: assert property (p_imm_trip_opens) else $error("undelayed trip kept block closed"); // RULE5

  sequence s_delayed_entry;
    st_ff[0] == safety_pkg::ST_CLOSED && trip_dly[0] && !trip_imm[0] && !fb_fault[0] && active[0];
  endsequence
  sequence s_delay_quiet;
    !trip_imm[0] && !fb_fault[0] && active[0];
  endsequence
  // A ten-tick delay keeps the block closed for eleven cycles after the delayed trip and then opens it.
  property p_delay_holds;
    s_delayed_entry ##0 delay_ff[0] == DLY_W'(10) ##1 s_delay_quiet[*8] ##1 s_delay_quiet ##1 s_delay_quiet
      |-> closed_ff[0] ##2 !closed_ff[0];
  endproperty
  a_delay_holds: assert property (p_delay_holds) else $error("delayed trip opened early"); // RULE5

  property p_auto_restart;
    st_ff[0] == safety_pkg::ST_OPEN && go[0] |=> closed_ff[0];
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("block did not reclose"); // RULE6

  property p_manual_waits;
    !closed_ff[1] && !blk_cfg_ff[`BLK_NIB_W + `BLK_AUTO] && !(start_btn[1] && !start_prev_ff[1]) |=> !closed_ff[1];
  endproperty
  a_manual_waits: assert property (p_manual_waits) else $error("manual block closed without start"); // RULE6

  property p_unmapped_keeps;
    closed_ff[1] && st_ff[1] == safety_pkg::ST_CLOSED && !trip_imm[1] && !trip_dly[1] && !fb_fault[1] && active[1]
      |=> closed_ff[1];
  endproperty
  a_unmapped_keeps: assert property (p_unmapped_keeps) else $error("block opened by foreign trip"); // RULE7

  property p_override_masks;
    override_sw && ((~safe_in & ~in_ovr) == '0) && st_ff[0] == safety_pkg::ST_CLOSED && !fb_fault[0] && active[0]
      |=> closed_ff[0];
  endproperty
  a_override_masks: assert property (p_override_masks) else $error("override not honoured"); // RULE8

endmodule
`default_nettype wire

// ### tb/contactor_model.sv
// Behavioural model of the external contactors that drive the feedback inputs.
`timescale 1ns/1ns
`default_nettype none
module contactor_model
(
  input wire logic ref_clk,
  input wire logic [1:0] block_closed,
  input wire logic [1:0] mode,
  output logic [1:0] fb_in
);
  // ======================================================================
  // Contact behaviour
  // Mode 0 is healthy: the NC contact opens one cycle after its block closes.
  // Mode 1 never pulls in, mode 2 is welded open, mode 3 is a chattering wire.
  logic [1:0] fb_ff = 2'h3;
  always @(posedge ref_clk)
  begin
    case (mode)
      2'h0: fb_ff <= ~block_closed;
      2'h1: fb_ff <= 2'h3;
      2'h2: fb_ff <= 2'h0;
      default: fb_ff <= ~fb_ff;
    endcase
  end
  assign fb_in = fb_ff;
endmodule
`default_nettype wire

// ### tb/test_safety_output_block_ctrl.sv
// Self-checking testbench of the output-block control.
`timescale 1ns/1ns
`default_nettype none
`include "safety_cfg.svh"
module test_safety_output_block_ctrl;
  localparam int FBT = 20;
  logic ref_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, override_sw = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irq, e;
  logic [5:0] safe_in = 6'h3f;
  logic [1:0] start_btn = 2'h0, fb_mode = 2'h1, fb_in, block_closed, block_pnp;
  int err_count = 0;
  int checks = 0;

  // ======================================================================
  // Clock, design and contactors
  always #4 ref_clk = ~ref_clk;
  safety_output_block_ctrl #(.NUM_IN(6), .DLY_W(32), .FB_TICKS(32'(FBT))) u_dut
  (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .safe_in, .start_btn, .override_sw, .fb_in, .block_closed, .block_pnp, .irq);
  contactor_model u_fb (.ref_clk(ref_clk), .block_closed(block_closed), .mode(fb_mode), .fb_in(fb_in));

  // ======================================================================
  // Helpers
  task chk(input logic [31:0] g, input logic [31:0] x, input string m);
    checks++;
    if (g !== x)
    begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // The request is held until pready is sampled high; the answer is taken at that edge.
  task apb(input int w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= 1'(w);
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    @(posedge ref_clk);
    while (pready !== 1'h1) @(posedge ref_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task wblk(input int i, input int v, input int lim);
    for (int n = 0; n < lim && block_closed[i] !== 1'(v); n++) @(posedge ref_clk);
    chk(32'(block_closed[i]), 32'(v), "block state");
  endtask
  task tally_and_finish;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ======================================================================
  // Scenarios
  task t_regs;
    apb(0, `IN_CFG_ADDR, 0); chk(r, `IN_CFG_RST, "in cfg reset");
    apb(0, `BLK_CFG_ADDR, 0); chk(r, 32'(`BLK_CFG_RST), "blk cfg reset");
    apb(0, `DELAY_B_ADDR, 0); chk(r, `DELAY_RST, "delay reset");
    apb(0, `IRQ_MASK_ADDR, 0); chk(r, 32'(`IRQ_MASK_RST), "mask reset");
    apb(1, `STATUS_ADDR, 32'hffff_ffff);
    apb(0, `STATUS_ADDR, 0); chk(r, 32'h0000_3f00, "status idle");
    apb(1, 8'h1c, 32'h1); chk(32'(e), 32'h1, "unmapped error");
    apb(1, `BLK_CFG_ADDR, 32'h88); cyc(2); chk(32'(block_pnp), 32'h3, "pnp type");
    // Block B stays unmapped, as a one-block controller needs.
    apb(1, `IN_CFG_ADDR, 32'h1);
    apb(0, `STATUS_ADDR, 0); chk(r, 32'h0000_3f01, "only A active");
    apb(1, `IN_CFG_ADDR, 32'h0);
    $display("test regs done");
  endtask
  task t_map;
    apb(1, `BLK_CFG_ADDR, 32'h44);
    apb(1, `IN_CFG_ADDR, 32'h32);
    wblk(0, 1, 8);
    wblk(1, 1, 8);
    apb(0, `IRQ_STAT_ADDR, 0);
    apb(1, `IRQ_MASK_ADDR, 32'h1);
    safe_in[0] <= 1'h0;
    wblk(1, 0, 4);
    chk(32'(block_closed[0]), 32'h1, "A untouched");
    chk(32'(irq), 32'h0, "irq masked");
    apb(1, `IRQ_MASK_ADDR, 32'h2); cyc(2); chk(32'(irq), 32'h1, "irq raised");
    apb(0, `IRQ_STAT_ADDR, 0); chk(r, 32'h2, "B opened event");
    cyc(2); chk(32'(irq), 32'h0, "irq cleared");
    safe_in[0] <= 1'h1;
    wblk(1, 1, 6);
    safe_in[1] <= 1'h0;
    wblk(0, 0, 4);
    chk(32'(block_closed[1]), 32'h0, "both opened");
    safe_in[1] <= 1'h1;
    apb(1, `IRQ_MASK_ADDR, 32'h0);
    $display("test map done");
  endtask
  task t_start;
    apb(1, `IN_CFG_ADDR, 32'h0); wblk(0, 0, 4);
    apb(1, `BLK_CFG_ADDR, 32'h0);
    apb(1, `IN_CFG_ADDR, 32'h1); cyc(8);
    chk(32'(block_closed[0]), 32'h0, "waits for button");
    start_btn[0] <= 1'h1; cyc(1); start_btn[0] <= 1'h0;
    wblk(0, 1, 4);
    $display("test start done");
  endtask
  task t_delay;
    apb(1, `IN_CFG_ADDR, 32'h0); wblk(0, 0, 4);
    apb(1, `DELAY_A_ADDR, 32'd10);
    apb(1, `BLK_CFG_ADDR, 32'h6);
    apb(1, `IN_CFG_ADDR, 32'h15); wblk(0, 1, 8);
    safe_in[0] <= 1'h0; cyc(10);
    chk(32'(block_closed[0]), 32'h1, "delay running");
    wblk(0, 0, 6);
    safe_in[0] <= 1'h1; wblk(0, 1, 8);
    safe_in[1] <= 1'h0; wblk(0, 0, 3);
    safe_in[1] <= 1'h1; wblk(0, 1, 8);
    apb(1, `BLK_CFG_ADDR, 32'h4);
    safe_in[0] <= 1'h0; wblk(0, 0, 3);
    safe_in[0] <= 1'h1; wblk(0, 1, 8);
    $display("test delay done");
  endtask
  task t_ovr;
    apb(1, `IN_CFG_ADDR, 32'h19);
    override_sw <= 1'h1;
    safe_in[0] <= 1'h0; cyc(6);
    chk(32'(block_closed[0]), 32'h1, "trip overridden");
    safe_in[0] <= 1'h1; safe_in[1] <= 1'h0;
    wblk(0, 0, 3);
    safe_in[1] <= 1'h1; override_sw <= 1'h0;
    $display("test override done");
  endtask
  task t_fb;
    apb(1, `IN_CFG_ADDR, 32'h0); wblk(0, 0, 4);
    apb(1, `BLK_CFG_ADDR, 32'h5);
    fb_mode <= 2'h2;
    apb(1, `IN_CFG_ADDR, 32'h1); cyc(10);
    chk(32'(block_closed[0]), 32'h0, "start refused");
    fb_mode <= 2'h0; wblk(0, 1, 6);
    cyc(40); chk(32'(block_closed[0]), 32'h1, "healthy contactor");
    apb(1, `IN_CFG_ADDR, 32'h0); wblk(0, 0, 4);
    fb_mode <= 2'h1; cyc(2);
    apb(0, `IRQ_STAT_ADDR, 0);
    apb(1, `IN_CFG_ADDR, 32'h1); wblk(0, 1, 6);
    cyc(FBT - 2); chk(32'(block_closed[0]), 32'h1, "check window");
    wblk(0, 0, 6);
    apb(1, `IN_CFG_ADDR, 32'h0);
    apb(0, `IRQ_STAT_ADDR, 0); chk(r & 32'h4, 32'h4, "fault event");
    $display("test feedback done");
  endtask
  task t_tog;
    apb(1, `BLK_CFG_ADDR, 32'h4);
    apb(1, `IN_CFG_ADDR, 32'h1); wblk(0, 1, 8);
    cyc(4); chk(32'(block_closed[0]), 32'h1, "steady feedback");
    fb_mode <= 2'h3; wblk(0, 0, 6);
    fb_mode <= 2'h1;
    $display("test toggle done");
  endtask

  // ======================================================================
  // Main sequence and watchdog; the whole run needs well under 2000 cycles.
  initial
  begin
    cyc(16);
    rst <= 1'h0;
    t_regs();
    t_map();
    t_start();
    t_delay();
    t_ovr();
    t_fb();
    t_tog();
    tally_and_finish();
  end
  initial
  begin
    cyc(20000);
    err_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
